// File: src/vcsr_pkg.sv
// Shared constants for the video control serial register block
package vcsr_pkg;

  // ==========================================================================
  // Register addresses, as carried in the address byte
  localparam logic [7:0] ADDR_STEPS_A = 8'h10;
  localparam logic [7:0] ADDR_STEPS_B = 8'h11;
  localparam logic [7:0] ADDR_STEPS_C = 8'h12;
  localparam logic [7:0] ADDR_STEPS_D = 8'h13;
  localparam logic [7:0] ADDR_MODE    = 8'h14;
  localparam logic [7:0] ADDR_TFLT    = 8'h15;
  localparam logic [7:0] ADDR_BOX_L   = 8'h16;
  localparam logic [7:0] ADDR_BOX_R   = 8'h17;

  // ==========================================================================
  // Field positions
  localparam int STEP_EVEN_LSB = 0;
  localparam int STEP_EVEN_MSB = 3;
  localparam int STEP_ODD_LSB  = 4;
  localparam int STEP_ODD_MSB  = 7;
  localparam int MODE_FIXK_LSB = 0;
  localparam int MODE_FIXK_MSB = 3;
  localparam int MODE_MULT_LSB = 4;
  localparam int MODE_MULT_MSB = 5;
  localparam int MODE_SRC_BIT  = 6;
  localparam int MODE_FIX_BIT  = 7;
  localparam int TFA_LSB       = 0;
  localparam int TFA_MSB       = 1;
  localparam int TFB_LSB       = 2;
  localparam int TFB_MSB       = 7;

  // ==========================================================================
  // Reset values
  localparam logic [7:0] RST_STEPS = 8'h00;
  localparam logic [7:0] RST_MODE  = 8'h00;
  localparam logic [7:0] RST_TFLT  = 8'h00;
  localparam logic [7:0] RST_BOX_L = 8'h00;
  localparam logic [7:0] RST_BOX_R = 8'h00;

  // ==========================================================================
  // Timing and counts
  localparam int LINE_CLKS_LO   = 864;
  localparam int LINE_CLKS_HI   = 1024;
  localparam int CHROMA_GROUP   = 4;
  localparam int BITS_PER_BYTE  = 8;
  localparam int LINK_CLK_NS    = 1000;
  localparam int SYS_CLK_NS     = 40;
  // Least byte pair time seen on the system side, in system clocks
  localparam int PAIR_SYS_CLKS  = (2 * BITS_PER_BYTE * LINK_CLK_NS) / SYS_CLK_NS;

  // Weights of the eight adaptive curve steps
  localparam logic [3:0] STEP_WEIGHT [8] = '{4'h1, 4'h1, 4'h2, 4'h2,
                                             4'h4, 4'h4, 4'h8, 4'h8};

  typedef enum logic [0:0] {
    LS_ADDR = 1'b0,
    LS_DATA = 1'b1
  } vcsr_link_state_type;

endpackage

// File: src/vcsr_top.sv
// Serial register link, sync references, box and field-memory enables
`timescale 1ns/1ps

// How it works
// - All video-side logic runs on the one line-locked system clock.
// - Delayed line sync rising edge restarts the four-clock chroma phase count.
// - Line sync reference is delayed by a selectable one to four clocks.
// - Box line counter steps on each line sync pulse.
// - Field sync rising edge clears the box line counter.
// - Memory A read, memory B read and write enables derive from master read.
// - Panel freeze output holds off display writing while active.
// - Spare output follows the line sequencer, one value per line.
// - Link clear asynchronously returns the link logic to idle.
// - Link clear release restarts the line sequencer phase.
// - Link data bits are timed by link clock; the pin is only received, never driven.
// - Address byte then data byte; data goes into the addressed register.
// - 10H..13H hold eight 4-bit curve steps, even step low, weighted 1,1,2,2,4,4,8,8.
// - 14H bits 0-3 static recursion factor, bits 4-5 filter B weighting.
// - 14H bit 6 picks mode decision source: 0 controller bit, 1 box.
// - 14H bit 7: 0 adaptive averaging, 1 fixed recursion factor.
// - 15H bits 0-1 filter A select, bits 2-7 filter B select.
// - 16H box left edge, 17H box right edge, eight bits each.
// - Horizontal box position counts from delayed line sync, vertical from field sync.
// - Under box control the box switches adaptive versus fixed by position.
module vcsr_top
  import vcsr_pkg::*;
#(
  parameter int          HCNT_W        = 10,       // Pixel counter width
  parameter logic [15:0] SPARE_PATTERN = 16'h0000  // Spare output per sequencer line
) (
  input  wire logic        clock,             // System clock, line locked
  input  wire logic        rst_n,             // Async reset, active low
  input  wire logic        link_clk,          // Serial link clock from controller
  input  wire logic        link_clear_n,      // Link clear, async, active low
  input  wire logic        link_dat_in,       // Link data pin, input side
  output logic             link_dat_out,      // Link data pin, output side
  output logic             link_dat_oe,       // Link data pin, output enable
  input  wire logic        line_sync_in,      // Line sync reference
  input  wire logic        field_sync_in,     // Field sync reference
  input  wire logic        master_rd_en,      // Master read enable
  input  wire logic [1:0]  line_sync_delay,   // Line sync delay, 0..3 = 1..4 clocks
  input  wire logic [1:0]  mem_b_wr_delay,    // Memory B write delay, 0..3 = 1..4 clocks
  input  wire logic        vsrc_line_repeat,  // Conversion repeats current line
  input  wire logic [8:0]  box_top,           // Box first line
  input  wire logic [8:0]  box_bottom,        // Box last line
  input  wire logic        freeze_req,        // Panel freeze request
  output logic             mem_a_rd_en,       // Field memory A read enable
  output logic             mem_b_rd_en,       // Field memory B read enable
  output logic             mem_b_wr_en,       // Field memory B write enable
  output logic             panel_freeze,      // Hold display writing
  output logic             spare_out,         // Spare line sequencer output
  output logic             line_sync_dly,     // Delayed line sync edge pulse
  output logic [1:0]       chroma_phase,      // Chroma sample phase 0..3
  output logic [8:0]       box_line,          // Box line counter
  output logic             box_active,        // Inside the box
  output logic             nr_fixed_mode,     // Noise reduction fixed factor
  output logic [31:0]      nr_curve_steps,    // Eight 4-bit curve steps
  output logic [8:0]       nr_curve_total,    // Weighted sum of curve steps
  output logic [3:0]       static_k,          // Recursion factor in static mode
  output logic [1:0]       filter_b_weight,   // Filter B output weighting
  output logic [1:0]       temp_flt_a_sel,    // Filter A characteristic
  output logic [5:0]       temp_flt_b_sel,    // Filter B characteristic
  output logic [7:0]       box_left,          // Box left edge
  output logic [7:0]       box_right          // Box right edge
);

  // ==========================================================================
  // Link clock domain
  typedef struct packed {
    vcsr_link_state_type state;
    logic [2:0]          bit_cnt;
    logic [6:0]          shift;
    logic [7:0]          addr;
    logic [15:0]         word;
    logic                tgl;
  } vcsr_link_type;

  vcsr_link_type lnk_reg;
  vcsr_link_type lnk_next;
  logic          link_rst_n;

  assign link_rst_n = rst_n & link_clear_n;

  // Device only receives; the pin is never driven
  assign link_dat_out = 1'b0;
  assign link_dat_oe  = 1'b0;

  always_comb begin
    lnk_next         = lnk_reg;
    lnk_next.shift   = {link_dat_in, lnk_reg.shift[6:1]};
    lnk_next.bit_cnt = lnk_reg.bit_cnt + 3'h1;
    if (lnk_reg.bit_cnt == 3'h7) begin
      case (lnk_reg.state)
        LS_ADDR: begin
          lnk_next.addr  = {link_dat_in, lnk_reg.shift};
          lnk_next.state = LS_DATA;
        end
        LS_DATA: begin
          lnk_next.word  = {lnk_reg.addr, link_dat_in, lnk_reg.shift};
          lnk_next.tgl   = ~lnk_reg.tgl;
          lnk_next.state = LS_ADDR;
        end
        default: begin
          lnk_next.state = LS_ADDR;
        end
      endcase
    end
  end

  // Held word changes only once per byte pair, so it is stable long after the toggle
  always_ff @(posedge link_clk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      lnk_reg <= '0;
    end else begin
      lnk_reg <= lnk_next;
    end
  end

  // ==========================================================================
  // System clock domain
  typedef struct packed {
    logic [2:0]      ls_s;
    logic [2:0]      fs_s;
    logic [1:0]      rd_s;
    logic [2:0]      clr_s;
    logic [2:0]      tg_s;
    logic [3:0]      ldly;
    logic [HCNT_W-1:0] hcnt;
    logic [8:0]      vcnt;
    logic [1:0]      cphase;
    logic [3:0]      seq;
    logic [3:0][7:0] steps;
    logic [7:0]      mode;
    logic [7:0]      tflt;
    logic [7:0]      boxl;
    logic [7:0]      boxr;
    logic            box_act;
    logic            fixed;
    logic            rd_a;
    logic            rd_b;
    logic            wr_b;
    logic [3:0]      wdly;
    logic            freeze;
    logic            spare;
    logic            ldly_out;
    logic [8:0]      total;
  } vcsr_sys_type;

  vcsr_sys_type sys_reg;
  vcsr_sys_type sys_next;

  // Weighted curve endpoint over all eight steps
  function automatic logic [8:0] curve_total(input logic [3:0][7:0] s);
    logic [8:0] acc;
    logic [3:0] st;
    acc = 9'h000;
    for (int i = 0; i < 8; i++) begin
      st  = s[i/2][4*(i%2) +: 4];
      // Widen before the product so the heaviest steps do not wrap
      acc = acc + 9'(st) * 9'(STEP_WEIGHT[i]);
    end
    return acc;
  endfunction

  logic line_edge;
  logic field_edge;
  logic clr_rise;
  logic word_new;
  logic dly_pulse;
  logic in_h;
  logic in_v;

  always_comb begin
    sys_next = sys_reg;

    // Two flops before any logic; third flop only feeds edge detection
    sys_next.ls_s  = {sys_reg.ls_s[1:0], line_sync_in};
    sys_next.fs_s  = {sys_reg.fs_s[1:0], field_sync_in};
    sys_next.rd_s  = {sys_reg.rd_s[0], master_rd_en};
    sys_next.clr_s = {sys_reg.clr_s[1:0], link_clear_n};
    sys_next.tg_s  = {sys_reg.tg_s[1:0], lnk_reg.tgl};

    line_edge  = sys_reg.ls_s[1] & ~sys_reg.ls_s[2];
    field_edge = sys_reg.fs_s[1] & ~sys_reg.fs_s[2];
    clr_rise   = sys_reg.clr_s[1] & ~sys_reg.clr_s[2];
    word_new   = sys_reg.tg_s[1] ^ sys_reg.tg_s[2];

    // Line sync delay line, tap 0 is one clock
    sys_next.ldly     = {sys_reg.ldly[2:0], line_edge};
    dly_pulse         = sys_reg.ldly[line_sync_delay];
    sys_next.ldly_out = dly_pulse;

    // Chroma grouping restarts at the delayed edge
    if (dly_pulse) begin
      sys_next.cphase = 2'h0;
    end else begin
      sys_next.cphase = 2'(sys_reg.cphase + 2'h1);
    end

    // Pixel position from delayed line edge, saturating
    if (dly_pulse) begin
      sys_next.hcnt = '0;
    end else if (sys_reg.hcnt != '1) begin
      sys_next.hcnt = sys_reg.hcnt + 1'b1;
    end

    // Field edge wins over a coincident line edge
    if (field_edge) begin
      sys_next.vcnt = 9'h000;
    end else if (line_edge) begin
      sys_next.vcnt = 9'(sys_reg.vcnt + 9'h001);
    end

    // Line sequencer, restarted by link clear release
    if (clr_rise) begin
      sys_next.seq = 4'h0;
    end else if (line_edge) begin
      sys_next.seq = 4'(sys_reg.seq + 4'h1);
    end
    sys_next.spare = SPARE_PATTERN[sys_reg.seq];

    // Register writes; word is stable for many cycles after the toggle
    if (word_new) begin
      case (lnk_reg.word[15:8])
        ADDR_STEPS_A: sys_next.steps[0] = lnk_reg.word[7:0];
        ADDR_STEPS_B: sys_next.steps[1] = lnk_reg.word[7:0];
        ADDR_STEPS_C: sys_next.steps[2] = lnk_reg.word[7:0];
        ADDR_STEPS_D: sys_next.steps[3] = lnk_reg.word[7:0];
        ADDR_MODE:    sys_next.mode     = lnk_reg.word[7:0];
        ADDR_TFLT:    sys_next.tflt     = lnk_reg.word[7:0];
        ADDR_BOX_L:   sys_next.boxl     = lnk_reg.word[7:0];
        ADDR_BOX_R:   sys_next.boxr     = lnk_reg.word[7:0];
        default:      sys_next.mode     = sys_reg.mode;
      endcase
    end
    sys_next.total = curve_total(sys_reg.steps);

    // Box: horizontal coordinates in units of four pixels, vertical in lines
    in_h = (sys_reg.hcnt[HCNT_W-1 -: 8] >= sys_reg.boxl) &&
           (sys_reg.hcnt[HCNT_W-1 -: 8] <= sys_reg.boxr);
    in_v = (sys_reg.vcnt >= box_top) && (sys_reg.vcnt <= box_bottom);
    sys_next.box_act = in_h & in_v;

    // Mode decision: controller bit, or box selects the fixed factor inside
    if (sys_reg.mode[MODE_SRC_BIT]) begin
      sys_next.fixed = sys_reg.box_act;
    end else begin
      sys_next.fixed = sys_reg.mode[MODE_FIX_BIT];
    end

    // Memory enables from master read
    sys_next.rd_a = sys_reg.rd_s[1];
    sys_next.rd_b = sys_reg.rd_s[1] & ~vsrc_line_repeat;
    sys_next.wdly = {sys_reg.wdly[2:0], sys_reg.rd_s[1] & ~vsrc_line_repeat};
    sys_next.wr_b = sys_reg.wdly[mem_b_wr_delay];

    // Freeze changes only at field start so whole fields are held
    if (field_edge) begin
      sys_next.freeze = freeze_req;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sys_reg       <= '0;
      sys_reg.steps <= {RST_STEPS, RST_STEPS, RST_STEPS, RST_STEPS};
      sys_reg.mode  <= RST_MODE;
      sys_reg.tflt  <= RST_TFLT;
      sys_reg.boxl  <= RST_BOX_L;
      sys_reg.boxr  <= RST_BOX_R;
      // Link clear idles high, so reset release is no false edge
      sys_reg.clr_s <= '1;
    end else begin
      sys_reg <= sys_next;
    end
  end

  // ==========================================================================
  // Outputs
  assign mem_a_rd_en     = sys_reg.rd_a;
  assign mem_b_rd_en     = sys_reg.rd_b;
  assign mem_b_wr_en     = sys_reg.wr_b;
  assign panel_freeze    = sys_reg.freeze;
  assign spare_out       = sys_reg.spare;
  assign line_sync_dly   = sys_reg.ldly_out;
  assign chroma_phase    = sys_reg.cphase;
  assign box_line        = sys_reg.vcnt;
  assign box_active      = sys_reg.box_act;
  assign nr_fixed_mode   = sys_reg.fixed;
  assign nr_curve_steps  = sys_reg.steps;
  assign nr_curve_total  = sys_reg.total;
  assign static_k        = sys_reg.mode[MODE_FIXK_MSB:MODE_FIXK_LSB];
  assign filter_b_weight = sys_reg.mode[MODE_MULT_MSB:MODE_MULT_LSB];
  assign temp_flt_a_sel  = sys_reg.tflt[TFA_MSB:TFA_LSB];
  assign temp_flt_b_sel  = sys_reg.tflt[TFB_MSB:TFB_LSB];
  assign box_left        = sys_reg.boxl;
  assign box_right       = sys_reg.boxr;

endmodule

// File: tb/vcsr_top_asserts.sv
// Concurrent checks on the ports of the serial register block
`timescale 1ns/1ps
module vcsr_top_asserts (
  input wire logic       clock,         // System clock
  input wire logic       rst_n,         // Async reset, active low
  input wire logic       line_sync_in,  // Line sync reference
  input wire logic       field_sync_in, // Field sync reference
  input wire logic       master_rd_en,  // Master read enable
  input wire logic       link_dat_oe,   // Link data pin enable
  input wire logic       mem_a_rd_en,   // Memory A read enable
  input wire logic       mem_b_rd_en,   // Memory B read enable
  input wire logic       mem_b_wr_en,   // Memory B write enable
  input wire logic       line_sync_dly, // Delayed line sync pulse
  input wire logic [1:0] chroma_phase,  // Chroma sample phase
  input wire logic [8:0] box_line       // Box line counter
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  // ==========
  // Link pin and sync references
  property p_link_quiet; !link_dat_oe; endproperty
  a_link_quiet: assert property (p_link_quiet) else $error("link pin driven");
  property p_dly_pulse; line_sync_dly |=> !line_sync_dly; endproperty
  a_dly_pulse: assert property (p_dly_pulse) else $error("sync pulse too long");
  // Widest tap plus sync stages bounds the wait
  property p_dly_cause; $rose(line_sync_in) |-> ##[4:8] line_sync_dly; endproperty
  a_dly_cause: assert property (p_dly_cause) else $error("no delayed sync");
  property p_phase_restart; line_sync_dly |-> chroma_phase == 2'h0; endproperty
  a_phase_restart: assert property (p_phase_restart) else $error("phase not reset");
  property p_field_clear; $rose(field_sync_in) |-> ##[2:6] (box_line == 9'h000); endproperty
  a_field_clear: assert property (p_field_clear) else $error("line count not cleared");
  property p_line_step;
    $changed(box_line) |-> (box_line == 9'h000 || box_line == $past(box_line) + 9'h001);
  endproperty
  a_line_step: assert property (p_line_step) else $error("line count jumped");

  // ==========
  // Field memory enables
  property p_mem_a; $rose(master_rd_en) |-> ##[2:4] mem_a_rd_en; endproperty
  a_mem_a: assert property (p_mem_a) else $error("memory A read late");
  property p_mem_b_rd; mem_b_rd_en |-> mem_a_rd_en; endproperty
  a_mem_b_rd: assert property (p_mem_b_rd) else $error("memory B read alone");
  property p_mem_b_wr;
    $rose(mem_b_wr_en) |-> ($past(mem_b_rd_en) || $past(mem_b_rd_en, 2) ||
                            $past(mem_b_rd_en, 3) || $past(mem_b_rd_en, 4));
  endproperty
  a_mem_b_wr: assert property (p_mem_b_wr) else $error("memory B write uncaused");
endmodule

bind vcsr_top vcsr_top_asserts i_vcsr_top_asserts (
  .clock(clock), .rst_n(rst_n), .line_sync_in(line_sync_in),
  .field_sync_in(field_sync_in), .master_rd_en(master_rd_en), .link_dat_oe(link_dat_oe),
  .mem_a_rd_en(mem_a_rd_en), .mem_b_rd_en(mem_b_rd_en), .mem_b_wr_en(mem_b_wr_en),
  .line_sync_dly(line_sync_dly), .chroma_phase(chroma_phase), .box_line(box_line));

// File: tb/vcsr_ctrl_model.sv
// Controller model of the serial link, shift-register port style
`timescale 1ns/1ps
module vcsr_ctrl_model (
  output logic link_clk, // Link clock, still and high between frames
  output logic link_dat  // Link data toward the device
);
  localparam int HALF_NS = 32;

  initial begin
    link_clk = 1'b1;
    link_dat = 1'b1;
  end

  // Data moves on the falling edge so it is stable at the sampling rise
  task automatic send_bits(input logic [15:0] bits, input int nbits);
    #7;
    for (int i = 0; i < nbits; i++) begin
      link_clk = 1'b0;
      link_dat = bits[i];
      #HALF_NS;
      link_clk = 1'b1;
      #HALF_NS;
    end
    link_dat = ~link_dat; // Released line must not show a stale bit
  endtask

  task automatic send_pair(input logic [7:0] addr, input logic [7:0] data);
    send_bits({data, addr}, 16);
  endtask
endmodule

// File: tb/vcsr_top_tb.sv
// Self-checking bench for the serial register block
`timescale 1ns/1ps
module vcsr_top_tb;
  import vcsr_pkg::*;
  localparam logic [15:0] PAT = 16'h5a5a;
  logic        clock = 1'b0, rst_n = 1'b0, link_clear_n = 1'b0;
  logic        line_sync_in = 1'b0, field_sync_in = 1'b0, master_rd_en = 1'b0;
  logic        vsrc_line_repeat = 1'b0, freeze_req = 1'b0;
  logic [1:0]  line_sync_delay = 2'h0, mem_b_wr_delay = 2'h0;
  logic [8:0]  box_top = 9'h002, box_bottom = 9'h005;
  logic        link_clk, link_dat, link_dat_in, link_dat_out, link_dat_oe;
  logic        mem_a_rd_en, mem_b_rd_en, mem_b_wr_en, panel_freeze, spare_out;
  logic        line_sync_dly, box_active, nr_fixed_mode;
  logic [1:0]  chroma_phase, filter_b_weight, temp_flt_a_sel;
  logic [3:0]  static_k;
  logic [5:0]  temp_flt_b_sel;
  logic [7:0]  box_left, box_right, v;
  logic [8:0]  box_line, nr_curve_total;
  logic [31:0] nr_curve_steps;
  logic [7:0]  shadow [8] = '{default: 8'h00};
  logic [7:0]  bad_addr [5] = '{8'h0f, 8'h18, 8'h1f, 8'h50, 8'h90};
  int          errors = 0, checks_done = 0, seed = 12141, cnt, base, n;

  assign link_dat_in = link_dat_oe ? link_dat_out : link_dat;
  always #20 clock = ~clock;

  vcsr_top #(.SPARE_PATTERN(PAT)) i_vcsr_top (
    .clock(clock), .rst_n(rst_n), .link_clk(link_clk), .link_clear_n(link_clear_n),
    .link_dat_in(link_dat_in), .link_dat_out(link_dat_out), .link_dat_oe(link_dat_oe),
    .line_sync_in(line_sync_in), .field_sync_in(field_sync_in), .master_rd_en(master_rd_en),
    .line_sync_delay(line_sync_delay), .mem_b_wr_delay(mem_b_wr_delay),
    .vsrc_line_repeat(vsrc_line_repeat), .box_top(box_top), .box_bottom(box_bottom),
    .freeze_req(freeze_req), .mem_a_rd_en(mem_a_rd_en), .mem_b_rd_en(mem_b_rd_en),
    .mem_b_wr_en(mem_b_wr_en), .panel_freeze(panel_freeze), .spare_out(spare_out),
    .line_sync_dly(line_sync_dly), .chroma_phase(chroma_phase), .box_line(box_line),
    .box_active(box_active), .nr_fixed_mode(nr_fixed_mode), .nr_curve_steps(nr_curve_steps),
    .nr_curve_total(nr_curve_total), .static_k(static_k), .filter_b_weight(filter_b_weight),
    .temp_flt_a_sel(temp_flt_a_sel), .temp_flt_b_sel(temp_flt_b_sel), .box_left(box_left),
    .box_right(box_right));
  vcsr_ctrl_model i_vcsr_ctrl_model (.link_clk(link_clk), .link_dat(link_dat));

  // ==========
  // Checking and expectation helpers
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic end_sim;
    $display("errors %0d checks_done %0d", errors, checks_done);
    if (errors == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  function automatic logic [8:0] total_exp();
    logic [8:0] s;
    s = 9'h000;
    for (int i = 0; i < 8; i++) s = s + 9'(shadow[i / 2][4 * (i % 2) +: 4]) * 9'(STEP_WEIGHT[i]);
    return s;
  endfunction

  task automatic check_regs;
    check("steps", nr_curve_steps, {shadow[3], shadow[2], shadow[1], shadow[0]});
    check("total", 32'(nr_curve_total), 32'(total_exp()));
    check("static_k", 32'(static_k), 32'(shadow[4][3:0]));
    check("weight", 32'(filter_b_weight), 32'(shadow[4][5:4]));
    // Box control is only selected while the box is known to be inactive
    check("fixed", nr_fixed_mode, shadow[4][6] ? 1'b0 : shadow[4][7]);
    check("flt_a", 32'(temp_flt_a_sel), 32'(shadow[5][1:0]));
    check("flt_b", 32'(temp_flt_b_sel), 32'(shadow[5][7:2]));
    check("left", 32'(box_left), 32'(shadow[6]));
    check("right", 32'(box_right), 32'(shadow[7]));
    check("pin", 32'({link_dat_oe, link_dat_out}), 32'h0);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    i_vcsr_ctrl_model.send_pair(a, d);
    if (a >= ADDR_STEPS_A && a <= ADDR_BOX_R) shadow[a - ADDR_STEPS_A] = d;
    repeat (8) @(negedge clock);
    check_regs();
  endtask

  task automatic sync_pulse(input logic fld);
    if (fld) field_sync_in = 1'b1;
    else line_sync_in = 1'b1;
    repeat (4) @(negedge clock);
    field_sync_in = 1'b0;
    line_sync_in = 1'b0;
    repeat (12) @(negedge clock);
  endtask

  // ==========
  // Main sequence
  initial begin
    repeat (2) @(negedge clock);
    rst_n = 1'b1;
    link_clear_n = 1'b1;
    repeat (4) @(negedge clock);
    check_regs();
    for (int r = 0; r < 2; r++)
      for (int a = 0; a < 8; a++) begin
        v = 8'($random(seed));
        v[6] = (a == 4) ? 1'b0 : v[6];
        wr(ADDR_STEPS_A + 8'(a), v);
      end
    for (int a = 0; a < 4; a++) wr(ADDR_STEPS_A + 8'(a), 8'hff);
    foreach (bad_addr[i]) wr(bad_addr[i], 8'($random(seed)));
    i_vcsr_ctrl_model.send_pair(ADDR_BOX_L, 8'h3c);
    i_vcsr_ctrl_model.send_pair(ADDR_BOX_R, 8'hc3);
    shadow[6] = 8'h3c;
    shadow[7] = 8'hc3;
    wr(ADDR_TFLT, 8'($random(seed)));
    for (int d = 0; d < 4; d++) begin
      line_sync_delay = 2'(d);
      repeat (16) @(negedge clock);
      line_sync_in = 1'b1;
      cnt = 0;
      while (line_sync_dly !== 1'b1 && cnt < 20) begin
        @(negedge clock);
        cnt++;
      end
      if (cnt >= 20) begin
        check("sync_wait", 1'b0, 1'b1);
        end_sim();
      end
      base = (d == 0) ? cnt : base;
      check("sync_tap", cnt - d, base);
      check("phase0", chroma_phase, 2'h0);
      @(negedge clock);
      check("phase1", chroma_phase, 2'h1);
      line_sync_in = 1'b0;
    end
    check("sync_base", base >= 4 && base <= 6, 1'b1);
    freeze_req = 1'b1;
    sync_pulse(1'b1);
    check("line_clr", box_line, 9'h000);
    check("outside", box_active, 1'b0);
    check("freeze_on", panel_freeze, 1'b1);
    freeze_req = 1'b0;
    wr(ADDR_MODE, 8'hc3);
    n = 3 + ($unsigned($random(seed)) % 6);
    repeat (n) sync_pulse(1'b0);
    check("line_cnt", box_line, 9'(n));
    // Well inside the horizontal limits here; the vertical limits decide
    repeat (300) @(negedge clock);
    check("inside", box_active, 9'(n) >= box_top && 9'(n) <= box_bottom);
    check("box_fixed", nr_fixed_mode, 9'(n) >= box_top && 9'(n) <= box_bottom);
    check("freeze_held", panel_freeze, 1'b1);
    sync_pulse(1'b1);
    check("freeze_off", panel_freeze, 1'b0);
    mem_b_wr_delay = 2'($random(seed));
    master_rd_en = 1'b1;
    repeat (10) @(negedge clock);
    check("rd_a", mem_a_rd_en, 1'b1);
    check("rd_b", mem_b_rd_en, 1'b1);
    check("wr_b", mem_b_wr_en, 1'b1);
    vsrc_line_repeat = 1'b1;
    repeat (10) @(negedge clock);
    check("rd_b_rep", mem_b_rd_en, 1'b0);
    check("wr_b_rep", mem_b_wr_en, 1'b0);
    check("rd_a_rep", mem_a_rd_en, 1'b1);
    master_rd_en = 1'b0;
    vsrc_line_repeat = 1'b0;
    repeat (10) @(negedge clock);
    check("rd_a_off", mem_a_rd_en, 1'b0);
    // A cut byte must not shift the next pair out of step
    i_vcsr_ctrl_model.send_bits(16'h0014, 5);
    @(negedge clock);
    link_clear_n = 1'b0;
    repeat (3) @(negedge clock);
    link_clear_n = 1'b1;
    repeat (6) @(negedge clock);
    check("seq_start", spare_out, PAT[0]);
    wr(ADDR_BOX_L, 8'($random(seed)));
    sync_pulse(1'b0);
    check("seq_next", spare_out, PAT[1]);
    end_sim();
  end
endmodule
